// *** pkg/fcr_cfg.svh ***
// Offsets, field positions, opcodes and reset values of the configuration registers
`ifndef FCR_CFG_SVH
`define FCR_CFG_SVH

`define FCR_OP_WR_ENABLE   8'h06
`define FCR_OP_WRFN        8'h42
`define FCR_OP_RP_PERSIST  8'h65
`define FCR_OP_RP_WORK     8'h63
`define FCR_OP_RP_WORK_NW  8'hc0
`define FCR_OP_RD_FN       8'h48
`define FCR_OP_RD_RP       8'h61

`define FCR_BIT_OP_LAST    5'h07
`define FCR_BIT_DAT_LAST   5'h0f
`define FCR_BIT_SAT        5'h10

`define FCR_FN_OTP_MASK    8'hf3
`define FCR_FN_RSTDIS      0
`define FCR_FN_SIDE        1
`define FCR_FN_PROG_SUSP   2
`define FCR_FN_ERASE_SUSP  3
`define FCR_FN_LOCK_LSB    4
`define FCR_FN_LOCK_MSB    7

`define FCR_RP_PINSEL      7
`define FCR_RP_DUMMY_MSB   6
`define FCR_RP_DUMMY_LSB   3
`define FCR_RP_WRAP_EN     2
`define FCR_RP_BURST_MSB   1
`define FCR_RP_BURST_LSB   0

`define FCR_FN_RESET       8'h00
`define FCR_RP_RESET       8'h00
`define FCR_NV_FN          1'b0
`define FCR_NV_RP          1'b1

`define FCR_BLOCKS         10'h200
`define FCR_CODE_ALL       4'ha
`define FCR_WRAP_BASE      7'h08

`endif

// *** pkg/fcr_pkg.sv ***
// Types shared by the configuration register block
package fcr_pkg;

  typedef enum logic [1:0] {FCR_LOAD_FN, FCR_LOAD_RP, FCR_LOAD_END, FCR_RUN} fcr_boot_t;

  typedef struct packed {
    fcr_boot_t  boot;
    logic [7:0] fn;
    logic [7:0] rp;
    logic       wel;
    logic       c_s1;
    logic       c_s2;
    logic       c_s3;
    logic [7:0] snap_fn;
    logic [7:0] snap_rp;
    logic       snap_tgl;
    logic       a_s1;
    logic       a_s2;
    logic       prot_hit;
    logic       pin_pause;
    logic       pin_reset;
    logic       pin_data3;
    logic       ded_rst_en;
    logic [3:0] dummy;
    logic       dummy_def;
    logic       wrap_all;
    logic [6:0] wrap_bytes;
  } fcr_core_t;

  typedef struct packed {
    logic [4:0] bit_cnt;
    logic [7:0] sh;
    logic [7:0] op;
    logic [7:0] rd_sh;
    logic       so;
    logic       so_oe;
  } fcr_frame_t;

  typedef struct packed {
    logic [7:0] cmd_op;
    logic [7:0] cmd_dat;
    logic       cmd_tgl;
    logic       v_s1;
    logic       v_s2;
    logic       v_s3;
    logic [7:0] view_fn;
    logic [7:0] view_rp;
  } fcr_hold_t;

endpackage

// *** pkg/fcr_mem_if.sv ***
// Port group between the register core and its persistent store
`timescale 1ns/1ps
interface fcr_mem_if;
  logic       wr_en;
  logic       wr_addr;
  logic [7:0] wr_data;
  logic       rd_addr;
  logic [7:0] rd_data;

  modport core  (output wr_en, output wr_addr, output wr_data, output rd_addr, input rd_data);
  modport store (input wr_en, input wr_addr, input wr_data, input rd_addr, output rd_data);
endinterface

// *** src/fcr_nv_store.sv ***
// Persistent two-word store: function OTP bits and the persistent read parameters
`timescale 1ns/1ps
`include "fcr_cfg.svh"
module fcr_nv_store #(
  parameter logic RSTDIS_DEFAULT = 1'b0
) (
  input  wire logic clock,
  input  wire logic rst_n,
  fcr_mem_if.store  mem
);

  logic [7:0] word_reg [2];
  logic [7:0] rd_reg;

  // Reset stands in for the factory-programmed contents
  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
    begin
      word_reg[0] <= `FCR_FN_RESET | {7'h00, RSTDIS_DEFAULT};
      word_reg[1] <= `FCR_RP_RESET;
      rd_reg      <= 8'h00;
    end
    else
    begin
      if (mem.wr_en)
        word_reg[mem.wr_addr] <= mem.wr_data;
      rd_reg <= word_reg[mem.rd_addr];
    end
  end

  assign mem.rd_data = rd_reg;

endmodule

// *** src/fcr_top.sv ***
// Function and read-parameter registers with their serial command front end
`timescale 1ns/1ps
`include "fcr_cfg.svh"
// Functional notes
// RQ1: Codes 1..9 protect 1,2,4..256 of 512 blocks; code 0 none.
// RQ2: Side 0 counts protected blocks down from 511, side 1 up from 0.
// RQ3: Codes 10 to 15 protect all 512 blocks on either side.
// RQ4: Function register: locks 7:4, erase suspend 3, program suspend 2, side 1, reset-disable 0.
// RQ5: OTP function bits once one never return to zero.
// RQ6: Reset-disable bit defaults per package; once set, reset moves to shared pin.
// RQ7: Side select defaults top; once set, bottom is permanent.
// RQ8: Program suspend flag sets on suspend during program, clears on resume.
// RQ9: Erase suspend flag sets on suspend during erase, clears on resume.
// RQ10: Info row lock set to one blocks programming of that row forever.
// RQ11: Working read parameters load from persistent copy at power-up.
// RQ12: Read parameters: pin select 7, dummy 6:3, wrap 2, burst 1:0; default zero.
// RQ13: Pin select chooses pause or reset only single-line with quad off.
// RQ14: With dedicated reset pin, shared pin is pause when quad off, single-line.
// RQ15: Dummy field nonzero gives 1 to 15 dummy clocks.
// RQ16: Burst length 00..11 gives 8, 16, 32, 64 bytes.
// RQ17: Opcode 65h writes persistent copy; C0h or 63h writes working copy.
// RQ18: Dummy field zero selects each read command's default dummy count.
// RQ19: Wrap off wraps whole array; wrap on uses burst length.
// RQ20: Host may skip write enable before working-copy write with C0h.
// RQ21: Quad enable turns pause/reset and write-protect pins into data lines.
// RQ22: Writes leave the read-only suspend flags unchanged.
module fcr_top #(
  parameter logic RSTDIS_DEFAULT = 1'b0,
  parameter logic HAS_DED_RESET  = 1'b1
) (
  input  wire logic       clock,
  input  wire logic       rst_n,
  input  wire logic       sck,
  input  wire logic       cs_n,
  input  wire logic       si,
  output wire logic       so,
  output wire logic       so_oe,
  input  wire logic       quad_lines_enable,
  input  wire logic       four_line_command_mode,
  input  wire logic [3:0] protect_code,
  input  wire logic [8:0] block_addr,
  input  wire logic       program_active,
  input  wire logic       erase_active,
  input  wire logic       suspend_req,
  input  wire logic       resume_req,
  output wire logic       config_ready,
  output wire logic       block_protected,
  output wire logic [3:0] info_row_lock,
  output wire logic       protect_side_select,
  output wire logic       program_suspended_flag,
  output wire logic       erase_suspended_flag,
  output wire logic       dedicated_reset_enable,
  output wire logic       pin_function_pause,
  output wire logic       pin_function_reset,
  output wire logic       data_line_three,
  output wire logic [3:0] dummy_cycles,
  output wire logic       dummy_default,
  output wire logic       wrap_whole_array,
  output wire logic [6:0] wrap_bytes
);

  fcr_pkg::fcr_core_t  core_reg, core_next;
  fcr_pkg::fcr_frame_t frame_reg, frame_next;
  fcr_pkg::fcr_hold_t  hold_reg, hold_next;
  fcr_mem_if           mem ();
  logic                frame_rst_n;
  logic [7:0]          byte_in;
  logic                cmd_seen;

  fcr_nv_store #(
    .RSTDIS_DEFAULT (RSTDIS_DEFAULT)
  ) u_store (
    .clock (clock),
    .rst_n (rst_n),
    .mem   (mem)
  );

  function automatic logic prot_decode(
    input logic [3:0] code,
    input logic       side,
    input logic [8:0] blk
  );
    logic [9:0] cnt;
    logic [9:0] b;
    cnt = 10'h000;
    b   = {1'b0, blk};
    if (code >= `FCR_CODE_ALL)
      cnt = `FCR_BLOCKS; // RQ3
    else if (code != 4'h0)
      cnt = 10'h001 << (code - 4'h1); // RQ1
    if (side)
      return b < cnt; // RQ2
    return b >= (`FCR_BLOCKS - cnt); // RQ2
  endfunction

  function automatic logic is_write_op(input logic [7:0] op);
    return op == `FCR_OP_WRFN || op == `FCR_OP_RP_PERSIST ||
           op == `FCR_OP_RP_WORK || op == `FCR_OP_RP_WORK_NW;
  endfunction

  // Link side: frame logic is cleared by chip select, since the clock stops between frames
  assign frame_rst_n = rst_n & ~cs_n;
  assign byte_in     = {frame_reg.sh[6:0], si};

  always_comb
  begin
    frame_next = frame_reg;
    if (frame_reg.bit_cnt != `FCR_BIT_SAT)
      frame_next.bit_cnt = frame_reg.bit_cnt + 5'h01;
    frame_next.sh = byte_in;
    frame_next.so = frame_reg.rd_sh[7];
    frame_next.rd_sh = {frame_reg.rd_sh[6:0], 1'b0};
    if (frame_reg.bit_cnt == `FCR_BIT_OP_LAST)
    begin
      frame_next.op = byte_in;
      if (byte_in == `FCR_OP_RD_FN || byte_in == `FCR_OP_RD_RP)
      begin
        frame_next.so_oe = 1'b1;
        frame_next.so    = (byte_in == `FCR_OP_RD_FN) ? hold_reg.view_fn[7] : hold_reg.view_rp[7];
        frame_next.rd_sh = (byte_in == `FCR_OP_RD_FN) ? {hold_reg.view_fn[6:0], 1'b0}
                                                      : {hold_reg.view_rp[6:0], 1'b0};
      end
    end
  end

  always_ff @(posedge sck or negedge frame_rst_n)
  begin
    if (!frame_rst_n)
      frame_reg <= '0;
    else
      frame_reg <= frame_next;
  end

  // Command words cross by toggle; word stays put until the next command frame replaces it, with no acknowledge from the core
  always_comb
  begin
    hold_next = hold_reg;
    hold_next.v_s1 = core_reg.snap_tgl;
    hold_next.v_s2 = hold_reg.v_s1;
    hold_next.v_s3 = hold_reg.v_s2;
    if (hold_reg.v_s2 != hold_reg.v_s3)
    begin
      hold_next.view_fn = core_reg.snap_fn;
      hold_next.view_rp = core_reg.snap_rp;
    end
    if (frame_reg.bit_cnt == `FCR_BIT_OP_LAST && byte_in == `FCR_OP_WR_ENABLE)
    begin
      hold_next.cmd_op  = byte_in;
      hold_next.cmd_dat = 8'h00;
      hold_next.cmd_tgl = ~hold_reg.cmd_tgl;
    end
    else if (frame_reg.bit_cnt == `FCR_BIT_DAT_LAST && is_write_op(frame_reg.op))
    begin
      hold_next.cmd_op  = frame_reg.op; // RQ17
      hold_next.cmd_dat = byte_in;
      hold_next.cmd_tgl = ~hold_reg.cmd_tgl;
    end
  end

  always_ff @(posedge sck or negedge rst_n)
  begin
    if (!rst_n)
      hold_reg <= '0;
    else
      hold_reg <= hold_next;
  end

  assign so    = frame_reg.so;
  assign so_oe = frame_reg.so_oe;

  // Core side
  assign cmd_seen = (core_reg.c_s2 != core_reg.c_s3) && (core_reg.boot == fcr_pkg::FCR_RUN);

  always_comb
  begin
    core_next = core_reg;
    core_next.c_s1 = hold_reg.cmd_tgl;
    core_next.c_s2 = core_reg.c_s1;
    core_next.a_s1 = hold_reg.v_s3;
    core_next.a_s2 = core_reg.a_s1;
    mem.wr_en   = 1'b0;
    mem.wr_addr = `FCR_NV_FN;
    mem.wr_data = 8'h00;
    mem.rd_addr = `FCR_NV_FN;
    case (core_reg.boot)
      fcr_pkg::FCR_LOAD_FN:
      begin
        mem.rd_addr    = `FCR_NV_FN;
        core_next.boot = fcr_pkg::FCR_LOAD_RP;
      end
      fcr_pkg::FCR_LOAD_RP:
      begin
        mem.rd_addr    = `FCR_NV_RP;
        core_next.fn   = mem.rd_data & `FCR_FN_OTP_MASK;
        core_next.boot = fcr_pkg::FCR_LOAD_END;
      end
      fcr_pkg::FCR_LOAD_END:
      begin
        core_next.rp   = mem.rd_data; // RQ11
        core_next.boot = fcr_pkg::FCR_RUN;
      end
      fcr_pkg::FCR_RUN:
      begin
        // Held off until loaded so an early command is not lost
        core_next.c_s3 = core_reg.c_s2;
        if (cmd_seen)
        begin
          case (hold_reg.cmd_op)
            `FCR_OP_WR_ENABLE:
              core_next.wel = 1'b1;
            `FCR_OP_WRFN:
              if (core_reg.wel)
              begin
                // OR-in keeps OTP bits at one; suspend flags not writable
                core_next.fn  = core_reg.fn | (hold_reg.cmd_dat & `FCR_FN_OTP_MASK); // RQ5 RQ6 RQ7 RQ10 RQ22
                mem.wr_en     = 1'b1;
                mem.wr_addr   = `FCR_NV_FN;
                mem.wr_data   = (core_reg.fn | hold_reg.cmd_dat) & `FCR_FN_OTP_MASK; // RQ5
                core_next.wel = 1'b0;
              end
            `FCR_OP_RP_PERSIST:
              if (core_reg.wel)
              begin
                mem.wr_en     = 1'b1; // RQ17
                mem.wr_addr   = `FCR_NV_RP;
                mem.wr_data   = hold_reg.cmd_dat;
                core_next.wel = 1'b0;
              end
            `FCR_OP_RP_WORK:
              if (core_reg.wel)
              begin
                core_next.rp  = hold_reg.cmd_dat; // RQ17
                core_next.wel = 1'b0;
              end
            `FCR_OP_RP_WORK_NW:
            begin
              core_next.rp  = hold_reg.cmd_dat; // RQ17 RQ20
              core_next.wel = 1'b0;
            end
            default:
              core_next.wel = core_reg.wel;
          endcase
        end
      end
      default:
        core_next.boot = fcr_pkg::FCR_LOAD_FN;
    endcase
    // Set wins over resume in the same cycle
    core_next.fn[`FCR_FN_PROG_SUSP] = (core_reg.fn[`FCR_FN_PROG_SUSP] & ~resume_req) |
                                      (program_active & suspend_req); // RQ8
    core_next.fn[`FCR_FN_ERASE_SUSP] = (core_reg.fn[`FCR_FN_ERASE_SUSP] & ~resume_req) |
                                       (erase_active & suspend_req); // RQ9
    // Snapshot waits for the link's echo; link clock stops between frames, two toggles would cancel
    if ({core_reg.fn, core_reg.rp} != {core_reg.snap_fn, core_reg.snap_rp} &&
        core_reg.a_s2 == core_reg.snap_tgl)
    begin
      core_next.snap_fn  = core_reg.fn;
      core_next.snap_rp  = core_reg.rp;
      core_next.snap_tgl = ~core_reg.snap_tgl;
    end
    core_next.prot_hit = prot_decode(protect_code, core_reg.fn[`FCR_FN_SIDE], block_addr); // RQ1 RQ2 RQ3
    core_next.ded_rst_en = HAS_DED_RESET & ~core_reg.fn[`FCR_FN_RSTDIS]; // RQ6
    core_next.pin_data3 = quad_lines_enable | four_line_command_mode; // RQ13 RQ21
    if (core_next.pin_data3)
    begin
      core_next.pin_pause = 1'b0;
      core_next.pin_reset = 1'b0;
    end
    else if (HAS_DED_RESET && !core_reg.fn[`FCR_FN_RSTDIS])
    begin
      core_next.pin_pause = 1'b1; // RQ14
      core_next.pin_reset = 1'b0;
    end
    else
    begin
      core_next.pin_pause = ~core_reg.rp[`FCR_RP_PINSEL]; // RQ13
      core_next.pin_reset = core_reg.rp[`FCR_RP_PINSEL];
    end
    core_next.dummy     = core_reg.rp[`FCR_RP_DUMMY_MSB:`FCR_RP_DUMMY_LSB]; // RQ15
    core_next.dummy_def = core_reg.rp[`FCR_RP_DUMMY_MSB:`FCR_RP_DUMMY_LSB] == 4'h0; // RQ18
    core_next.wrap_all  = ~core_reg.rp[`FCR_RP_WRAP_EN]; // RQ19
    core_next.wrap_bytes = `FCR_WRAP_BASE << core_reg.rp[`FCR_RP_BURST_MSB:`FCR_RP_BURST_LSB]; // RQ16
  end

  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
    begin
      core_reg      <= '0; // RQ12
      core_reg.boot <= fcr_pkg::FCR_LOAD_FN;
    end
    else
      core_reg <= core_next;
  end

  assign config_ready           = core_reg.boot == fcr_pkg::FCR_RUN;
  assign block_protected        = core_reg.prot_hit;
  assign info_row_lock          = core_reg.fn[`FCR_FN_LOCK_MSB:`FCR_FN_LOCK_LSB]; // RQ4 RQ10
  assign protect_side_select    = core_reg.fn[`FCR_FN_SIDE];
  assign program_suspended_flag = core_reg.fn[`FCR_FN_PROG_SUSP];
  assign erase_suspended_flag   = core_reg.fn[`FCR_FN_ERASE_SUSP];
  assign dedicated_reset_enable = core_reg.ded_rst_en;
  assign pin_function_pause     = core_reg.pin_pause;
  assign pin_function_reset     = core_reg.pin_reset;
  assign data_line_three        = core_reg.pin_data3;
  assign dummy_cycles           = core_reg.dummy;
  assign dummy_default          = core_reg.dummy_def;
  assign wrap_whole_array       = core_reg.wrap_all;
  assign wrap_bytes             = core_reg.wrap_bytes;

  default clocking cb @(posedge clock);
  endclocking
  default disable iff (!rst_n);

  sequence boot_walk;
    core_reg.boot == fcr_pkg::FCR_LOAD_FN ##1 core_reg.boot == fcr_pkg::FCR_LOAD_RP
      ##1 core_reg.boot == fcr_pkg::FCR_LOAD_END;
  endsequence

  a_boot_load_done: assert property ((core_reg.boot == fcr_pkg::FCR_LOAD_FN) |-> boot_walk ##1 config_ready) // RQ11
    else $error("boot load did not finish in three cycles");
  a_otp_never_falls: assert property (((core_reg.fn & `FCR_FN_OTP_MASK) != 8'h00) && config_ready
      |=> ((core_reg.fn & $past(core_reg.fn) & `FCR_FN_OTP_MASK) == ($past(core_reg.fn) & `FCR_FN_OTP_MASK))) // RQ5
    else $error("OTP function bit returned to zero");
  a_prog_susp_sets: assert property (program_active && suspend_req |=> program_suspended_flag) // RQ8
    else $error("program suspend flag not set");
  a_erase_susp_sets: assert property (erase_active && suspend_req |=> erase_suspended_flag) // RQ9
    else $error("erase suspend flag not set");
  a_prog_susp_clear: assert property (resume_req && !suspend_req |=> !program_suspended_flag) // RQ8
    else $error("program suspend flag not cleared on resume");
  a_prot_code_none: assert property (protect_code == 4'h0 |=> !block_protected) // RQ1
    else $error("code zero protected a block");
  a_prot_code_all: assert property (protect_code >= `FCR_CODE_ALL |=> block_protected) // RQ3
    else $error("high code left a block unprotected");
  a_prot_top_one: assert property (protect_code == 4'h1 && !protect_side_select
      |=> block_protected == ($past(block_addr) == 9'h1ff)) // RQ2
    else $error("top single-block decode wrong");
  a_pin_data_three: assert property (quad_lines_enable ##1 quad_lines_enable
      |-> data_line_three && !pin_function_pause && !pin_function_reset) // RQ21
    else $error("quad mode left shared pin as pause or reset");
  a_nw_write_direct: assert property (cmd_seen && hold_reg.cmd_op == `FCR_OP_RP_WORK_NW
      |=> ##1 dummy_cycles == $past(hold_reg.cmd_dat[6:3], 2)) // RQ17
    else $error("working read parameters not taken from write");
  a_burst_max: assert property (config_ready && core_reg.rp[1:0] == 2'h3 |=> wrap_bytes == 7'h40) // RQ16
    else $error("burst code three not 64 bytes");

endmodule

// *** verif/fcr_host_model.sv ***
// Host serial controller model for the configuration link
`timescale 1ns/1ps
module fcr_host_model (
  output logic      sck,
  input  wire logic so,
  output logic      cs_n,
  output logic      si
);
  initial
  begin
    sck = 1'b0;
    cs_n = 1'b1;
    si = 1'b0;
  end
  // Clock runs only inside frames; released data line is inverted so it never looks valid
  task automatic frame(input logic [7:0] op, input logic [7:0] dat, output logic [7:0] rd);
    logic [15:0] word;
    word = {op, dat};
    rd = 8'h00;
    #17 cs_n = 1'b0;
    for (int i = 0; i < 16; i++)
    begin
      si = word[15 - i];
      #40 sck = 1'b1;
      #39 if (i >= 7 && i < 15) rd[14 - i] = so;
      #1 sck = 1'b0;
    end
    #23 cs_n = 1'b1;
    si = ~si;
  endtask
endmodule

// *** verif/flash_config_registers_bench.sv ***
// Self-checking bench for the configuration register block
`timescale 1ns/1ps
module flash_config_registers_bench;
  logic       clock = 1'b0;
  logic       rst_n = 1'b0;
  logic       quad = 1'b0;
  logic       four = 1'b0;
  logic [3:0] code = 4'h0;
  logic [8:0] blk = 9'h000;
  logic       prog = 1'b0;
  logic       ers = 1'b0;
  logic       susp = 1'b0;
  logic       resm = 1'b0;
  logic [7:0] rd;
  wire logic  sck, cs_n, si, so, so_oe, ready, prot, side, pgm_sus, ers_sus, ded, pp, pr, d3, ddef, wall;
  wire logic [3:0] lock, dummy;
  wire logic [6:0] wbytes;
  int         n_errors = 0;
  int         total_checks = 0;

  always #5 clock = ~clock;

  fcr_top uut (
    .clock(clock), .rst_n(rst_n), .sck(sck), .cs_n(cs_n), .si(si), .so(so), .so_oe(so_oe),
    .quad_lines_enable(quad), .four_line_command_mode(four), .protect_code(code), .block_addr(blk),
    .program_active(prog), .erase_active(ers), .suspend_req(susp), .resume_req(resm),
    .config_ready(ready), .block_protected(prot), .info_row_lock(lock), .protect_side_select(side),
    .program_suspended_flag(pgm_sus), .erase_suspended_flag(ers_sus), .dedicated_reset_enable(ded),
    .pin_function_pause(pp), .pin_function_reset(pr), .data_line_three(d3), .dummy_cycles(dummy),
    .dummy_default(ddef), .wrap_whole_array(wall), .wrap_bytes(wbytes)
  );

  fcr_host_model host (.sck(sck), .so(so), .cs_n(cs_n), .si(si));

  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    total_checks++;
    if (seen !== exp)
    begin
      n_errors++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic tick(input int n);
    repeat (n) @(posedge clock);
    #1;
  endtask

  task automatic wrap_up;
    $display("Checks %0d errors %0d", total_checks, n_errors);
    if (n_errors == 0 && total_checks > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask

  task automatic do_reset;
    @(posedge clock);
    rst_n <= 1'b0;
    tick(3);
    chk({ready, so_oe, lock, side, pgm_sus, ers_sus, ded, dummy}, 16'h0000);
    @(posedge clock);
    rst_n <= 1'b1;
    tick(5);
    chk(ready, 1'b1);
  endtask

  // Frames are spaced by the settle time the crossing needs
  task automatic wr(input logic [7:0] op, input logic [7:0] dat);
    host.frame(op, dat, rd);
    tick(8);
  endtask

  // First read may still show the old view, so the second one is judged
  task automatic rd_reg(input logic [7:0] op, input logic [7:0] exp);
    wr(op, 8'h00);
    wr(op, 8'h00);
    chk(rd, exp);
  endtask

  task automatic chk_rp(input logic [7:0] rp);
    chk(dummy, rp[6:3]);
    chk(ddef, rp[6:3] == 4'h0);
    chk(wall, !rp[2]);
    chk(wbytes, 7'h08 << rp[1:0]);
  endtask

  task automatic pchk(input logic [3:0] c, input logic [8:0] b, input logic exp);
    @(posedge clock);
    code <= c;
    blk <= b;
    tick(2);
    chk(prot, exp);
  endtask

  task automatic t_prot(input logic sd);
    int n;
    for (int c = 0; c < 16; c++)
    begin
      n = (c == 0) ? 0 : (c < 10) ? (1 << (c - 1)) : 512;
      pchk(4'(c), sd ? 9'h000 : 9'h1ff, n > 0);
      pchk(4'(c), sd ? 9'(n - 1) : 9'(512 - n), n > 0);
      if (n < 512)
        pchk(4'(c), sd ? 9'(n) : 9'(511 - n), 1'b0);
    end
  endtask

  task automatic t_rp;
    logic [7:0] v;
    for (int b = 0; b < 4; b++)
    begin
      v = {1'b0, 4'(b * 5), 1'(b), 2'(b)};
      wr(8'hc0, v);
      chk_rp(v);
    end
    rd_reg(8'h61, v);
    wr(8'h63, 8'h3a);
    chk_rp(v);
    wr(8'h06, 8'h00);
    wr(8'h63, 8'h3a);
    chk_rp(8'h3a);
    wr(8'h06, 8'h00);
    wr(8'h65, 8'h4e);
    chk_rp(8'h3a);
    chk(uut.u_store.word_reg[1], 8'h4e);
    // Store is cleared by the block reset, so the working copy reloads its reset value
    do_reset;
    chk_rp(8'h00);
  endtask

  task automatic setpin(input logic q, input logic f, input logic [2:0] exp);
    @(posedge clock);
    quad <= q;
    four <= f;
    tick(3);
    chk({pp, pr, d3}, exp);
  endtask

  task automatic t_pin;
    wr(8'hc0, 8'hce);
    setpin(1'b0, 1'b0, 3'b100);
    setpin(1'b1, 1'b0, 3'b001);
    setpin(1'b0, 1'b1, 3'b001);
    setpin(1'b0, 1'b0, 3'b100);
  endtask

  task automatic t_fn;
    chk(ded, 1'b1);
    wr(8'h06, 8'h00);
    wr(8'h42, 8'h0d);
    chk({lock, ers_sus, pgm_sus, side, ded}, 8'h00);
    wr(8'h06, 8'h00);
    wr(8'h42, 8'h52);
    chk({lock, ers_sus, pgm_sus, side, ded}, 8'h52);
    wr(8'h06, 8'h00);
    wr(8'h42, 8'h00);
    chk({lock, ers_sus, pgm_sus, side, ded}, 8'h52);
    wr(8'h42, 8'ha0);
    chk(lock, 4'h5);
    wr(8'h06, 8'h00);
    wr(8'h42, 8'ha0);
    chk({lock, ers_sus, pgm_sus, side, ded}, 8'hf2);
    rd_reg(8'h48, 8'hf3);
    setpin(1'b0, 1'b0, 3'b010);
    wr(8'hc0, 8'h4e);
    setpin(1'b0, 1'b0, 3'b100);
  endtask

  task automatic ev(input logic p, input logic e, input logic s, input logic r, input logic [1:0] exp);
    @(posedge clock);
    prog <= p;
    ers <= e;
    susp <= s;
    resm <= r;
    @(posedge clock);
    susp <= 1'b0;
    resm <= 1'b0;
    #1 chk({ers_sus, pgm_sus}, exp);
  endtask

  task automatic t_sus;
    ev(1'b1, 1'b0, 1'b1, 1'b0, 2'b01);
    rd_reg(8'h48, 8'hf7);
    ev(1'b1, 1'b0, 1'b0, 1'b1, 2'b00);
    ev(1'b0, 1'b1, 1'b1, 1'b0, 2'b10);
    wr(8'h06, 8'h00);
    wr(8'h42, 8'h00);
    chk(ers_sus, 1'b1);
    ev(1'b0, 1'b1, 1'b0, 1'b1, 2'b00);
    ev(1'b0, 1'b0, 1'b1, 1'b0, 2'b00);
  endtask

  initial
  begin
    do_reset;
    chk_rp(8'h00);
    t_prot(1'b0);
    t_rp;
    t_pin;
    t_fn;
    t_sus;
    t_prot(1'b1);
    wrap_up;
  end

  initial
  begin
    #400us;
    n_errors++;
    wrap_up;
  end
endmodule
